/* File: common/msg_port_pkg.sv */
// Package for the two-wire word messaging port: constants, states and carriers.
// Assumes a 10 MHz system clock and a bus clock from the host far slower than it.
// Behaviour
// - Messages travel as 32-bit words, four bytes.
// - Busy low when full; host pauses.
// - Stretch bus clock low when a word ends while busy.
// - Device acknowledges address and data bytes.
// - Busy rises only when words can be taken.
// - Data-ready request falls when outbound data pending.
// - Read address 0x81 acknowledged by device.
// - Read data changes after falling clock edge.
// - Device releases data line after each byte.
// - Request rises at last bit if empty.
// - Request refalls at acknowledge edge if queued.
// - Request inactive until boot helper image loaded.
// - Busy low while one-word receive buffer full.
package msg_port_pkg;

    localparam int WORD_BITS = 32;
    localparam int BYTES_PER_WORD = 4;
    localparam logic [6:0] SLAVE_ADDR = 7'h40;
    localparam logic [7:0] ADDR_WRITE = 8'h80;
    localparam logic [7:0] ADDR_READ = 8'h81;
    localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_RD_DATA,
        ST_RD_ACK,
        ST_IGNORE
    } port_state_t;

    // Word moving between the link domain and the system domain
    typedef struct packed {
        logic [WORD_BITS-1:0] data;
        logic valid;
    } msg_word_t;

    // Synchronised bus pin view, used by the event detector
    typedef struct packed {
        logic clk_rise;
        logic clk_fall;
        logic start;
        logic stop;
        logic sda;
    } bus_events_t;

endpackage

/* File: design/bus_event_detect.sv */
// Synchroniser and event detector for the two-wire bus pins.
// Assumes scl and sda come from pins outside the clk domain.
`timescale 1ns/1ps
module bus_event_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output msg_port_pkg::bus_events_t events
);
    logic [1:0] scl_sync_r, scl_sync_nxt;
    logic [1:0] sda_sync_r, sda_sync_nxt;
    logic scl_prev_r, scl_prev_nxt;
    logic sda_prev_r, sda_prev_nxt;

    always_comb begin
        // First stage is read only by the second stage
        scl_sync_nxt = {scl_sync_r[0], scl_in};
        sda_sync_nxt = {sda_sync_r[0], sda_in};
        scl_prev_nxt = scl_sync_r[1];
        sda_prev_nxt = sda_sync_r[1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= scl_sync_nxt;
            sda_sync_r <= sda_sync_nxt;
            scl_prev_r <= scl_prev_nxt;
            sda_prev_r <= sda_prev_nxt;
        end
    end

    always_comb begin
        events.clk_rise = scl_sync_r[1] & ~scl_prev_r;
        events.clk_fall = ~scl_sync_r[1] & scl_prev_r;
        events.start = scl_sync_r[1] & scl_prev_r & sda_prev_r & ~sda_sync_r[1];
        events.stop = scl_sync_r[1] & scl_prev_r & ~sda_prev_r & sda_sync_r[1];
        events.sda = sda_sync_r[1];
    end
endmodule // bus_event_detect

/* File: design/word_msg_port.sv */
// Slave side of the word messaging port over the two-wire bus.
// The bus clock is oversampled: the host clock must be well below clk/4 so that
// every bus edge is seen. Words go in and out through a valid/ready handshake.
`timescale 1ns/1ps
module word_msg_port (
    input wire logic clk,
    input wire logic reset,
    input wire logic serial_ctrl_clock_in,
    output logic serial_ctrl_clock_out,
    output logic serial_ctrl_clock_oe,
    input wire logic serial_ctrl_data_in,
    output logic serial_ctrl_data_out,
    output logic serial_ctrl_data_oe,
    output logic port_busy_n,
    output logic port_busy_n_oe,
    output logic data_ready_req_n,
    output logic data_ready_req_n_oe,
    input wire logic boot_helper_loaded,
    output msg_port_pkg::msg_word_t rx_word,
    input wire logic rx_ready,
    input wire msg_port_pkg::msg_word_t tx_word,
    output logic tx_ready
);
    msg_port_pkg::bus_events_t ev;

    bus_event_detect u_events (
        .clk(clk),
        .reset(reset),
        .scl_in(serial_ctrl_clock_in),
        .sda_in(serial_ctrl_data_in),
        .events(ev)
    );

    msg_port_pkg::port_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [1:0] byte_cnt_r, byte_cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [msg_port_pkg::WORD_BITS-1:0] rx_buf_r, rx_buf_nxt;
    // Bytes gather here so a held word is never overwritten by the next one
    logic [msg_port_pkg::WORD_BITS-1:0] asm_r, asm_nxt;
    logic [7:0] next_byte;
    logic rx_full_r, rx_full_nxt;
    logic [msg_port_pkg::WORD_BITS-1:0] tx_buf_r, tx_buf_nxt;
    logic tx_full_r, tx_full_nxt;
    logic [msg_port_pkg::WORD_BITS-1:0] out_word_r, out_word_nxt;
    logic out_busy_r, out_busy_nxt;
    logic sda_drive_r, sda_drive_nxt;
    logic req_low_r, req_low_nxt;
    logic req_hold_r, req_hold_nxt;
    logic stretch_r, stretch_nxt;
    logic booted_r, booted_nxt;

    function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] idx);
        // Bytes go out most significant first
        case (idx)
            2'h0: word_byte = w[31:24];
            2'h1: word_byte = w[23:16];
            2'h2: word_byte = w[15:8];
            default: word_byte = w[7:0];
        endcase
    endfunction

    logic data_pending;
    assign data_pending = out_busy_r | tx_full_r;

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        byte_cnt_nxt = byte_cnt_r;
        shift_nxt = shift_r;
        rx_buf_nxt = rx_buf_r;
        asm_nxt = asm_r;
        next_byte = word_byte(out_word_r, byte_cnt_r);
        rx_full_nxt = rx_full_r;
        tx_buf_nxt = tx_buf_r;
        tx_full_nxt = tx_full_r;
        out_word_nxt = out_word_r;
        out_busy_nxt = out_busy_r;
        sda_drive_nxt = sda_drive_r;
        req_low_nxt = req_low_r;
        req_hold_nxt = req_hold_r;
        stretch_nxt = stretch_r;
        booted_nxt = booted_r | boot_helper_loaded;

        // Consumer drains the receive buffer
        if (rx_full_r && rx_ready) begin
            rx_full_nxt = 1'b0;
        end
        // Producer fills a one-word staging slot
        if (!tx_full_r && tx_word.valid) begin
            tx_buf_nxt = tx_word.data;
            tx_full_nxt = 1'b1;
        end
        // Load the shift-out word when idle so the request reflects it
        if (!out_busy_r && tx_full_r && state_r != msg_port_pkg::ST_RD_DATA) begin
            out_word_nxt = tx_buf_r;
            out_busy_nxt = 1'b1;
            tx_full_nxt = 1'b0;
        end
        if (!req_hold_r && booted_r && (out_busy_r || tx_full_r)) begin
            req_low_nxt = 1'b1;
        end

        if (ev.start) begin
            // Start and repeated start behave the same
            state_nxt = msg_port_pkg::ST_ADDR;
            bit_cnt_nxt = 4'h0;
            sda_drive_nxt = 1'b0;
            req_hold_nxt = 1'b0;
        end else if (ev.stop) begin
            state_nxt = msg_port_pkg::ST_IDLE;
            sda_drive_nxt = 1'b0;
            req_hold_nxt = 1'b0;
            stretch_nxt = 1'b0;
        end else begin
            case (state_r)
                msg_port_pkg::ST_IDLE, msg_port_pkg::ST_IGNORE: begin
                    sda_drive_nxt = 1'b0;
                end
                msg_port_pkg::ST_ADDR, msg_port_pkg::ST_WR_DATA: begin
                    if (ev.clk_rise) begin
                        shift_nxt = {shift_r[6:0], ev.sda};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (ev.clk_fall && bit_cnt_r == msg_port_pkg::ACK_BIT_INDEX) begin
                        if (state_r == msg_port_pkg::ST_ADDR) begin
                            if (shift_r[7:1] == msg_port_pkg::SLAVE_ADDR) begin
                                sda_drive_nxt = 1'b1;
                                state_nxt = msg_port_pkg::ST_ADDR_ACK;
                            end else begin
                                state_nxt = msg_port_pkg::ST_IGNORE;
                            end
                        end else begin
                            asm_nxt = {asm_r[23:0], shift_r};
                            sda_drive_nxt = 1'b1;
                            state_nxt = msg_port_pkg::ST_WR_ACK;
                        end
                    end
                end
                msg_port_pkg::ST_ADDR_ACK: begin
                    if (ev.clk_fall) begin
                        bit_cnt_nxt = 4'h0;
                        byte_cnt_nxt = 2'h0;
                        if (shift_r[0]) begin
                            state_nxt = msg_port_pkg::ST_RD_DATA;
                            sda_drive_nxt = ~out_word_r[31];
                            shift_nxt = {out_word_r[30:24], 1'b1};
                        end else begin
                            state_nxt = msg_port_pkg::ST_WR_DATA;
                            sda_drive_nxt = 1'b0;
                        end
                    end
                end
                msg_port_pkg::ST_WR_ACK: begin
                    // Hold the clock low at the end of a word until the buffer empties
                    if (byte_cnt_r == msg_port_pkg::LAST_BYTE && rx_full_r && ev.clk_fall) begin
                        stretch_nxt = 1'b1;
                    end
                    if (ev.clk_fall && !stretch_r) begin
                        sda_drive_nxt = 1'b0;
                        bit_cnt_nxt = 4'h0;
                        byte_cnt_nxt = byte_cnt_r + 2'h1;
                        state_nxt = msg_port_pkg::ST_WR_DATA;
                        if (byte_cnt_r == msg_port_pkg::LAST_BYTE) begin
                            if (rx_full_r) begin
                                // Word lost would be worse than a stall
                                stretch_nxt = 1'b1;
                                state_nxt = msg_port_pkg::ST_WR_ACK;
                                sda_drive_nxt = 1'b0;
                            end else begin
                                rx_full_nxt = 1'b1;
                                rx_buf_nxt = asm_r;
                            end
                        end
                    end
                    if (stretch_r && !rx_full_r) begin
                        stretch_nxt = 1'b0;
                        rx_full_nxt = 1'b1;
                        rx_buf_nxt = asm_r;
                        bit_cnt_nxt = 4'h0;
                        byte_cnt_nxt = 2'h0;
                        state_nxt = msg_port_pkg::ST_WR_DATA;
                    end
                end
                msg_port_pkg::ST_RD_DATA: begin
                    if (ev.clk_rise) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h7 && byte_cnt_r == msg_port_pkg::LAST_BYTE) begin
                            out_busy_nxt = 1'b0;
                            if (!tx_full_r) begin
                                req_low_nxt = 1'b0;
                                req_hold_nxt = 1'b1;
                            end
                        end
                    end
                    if (ev.clk_fall && bit_cnt_r != 4'h0) begin
                        if (bit_cnt_r == msg_port_pkg::ACK_BIT_INDEX) begin
                            sda_drive_nxt = 1'b0;
                            state_nxt = msg_port_pkg::ST_RD_ACK;
                        end else begin
                            sda_drive_nxt = ~shift_r[7];
                            shift_nxt = {shift_r[6:0], 1'b1};
                        end
                    end
                end
                msg_port_pkg::ST_RD_ACK: begin
                    if (ev.clk_rise) begin
                        if (ev.sda) begin
                            state_nxt = msg_port_pkg::ST_IGNORE;
                            if (data_pending) begin
                                req_hold_nxt = 1'b0;
                                req_low_nxt = booted_r;
                            end
                        end else begin
                            byte_cnt_nxt = byte_cnt_r + 2'h1;
                            bit_cnt_nxt = 4'h0;
                        end
                    end
                    if (ev.clk_fall && !ev.sda) begin
                        state_nxt = msg_port_pkg::ST_RD_DATA;
                        bit_cnt_nxt = 4'h0;
                        if (byte_cnt_r == 2'h0 && !out_busy_r) begin
                            // Next word follows without a gap
                            out_word_nxt = tx_buf_r;
                            out_busy_nxt = tx_full_r;
                            tx_full_nxt = 1'b0;
                            sda_drive_nxt = ~tx_buf_r[31];
                            shift_nxt = {tx_buf_r[30:24], 1'b1};
                        end else begin
                            sda_drive_nxt = ~next_byte[7];
                            shift_nxt = {next_byte[6:0], 1'b1};
                        end
                    end
                end
                default: begin
                    state_nxt = msg_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= msg_port_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            byte_cnt_r <= 2'h0;
            shift_r <= 8'h00;
            rx_buf_r <= 32'h0000_0000;
            asm_r <= 32'h0000_0000;
            rx_full_r <= 1'b0;
            tx_buf_r <= 32'h0000_0000;
            tx_full_r <= 1'b0;
            out_word_r <= 32'h0000_0000;
            out_busy_r <= 1'b0;
            sda_drive_r <= 1'b0;
            req_low_r <= 1'b0;
            req_hold_r <= 1'b0;
            stretch_r <= 1'b0;
            booted_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            shift_r <= shift_nxt;
            rx_buf_r <= rx_buf_nxt;
            asm_r <= asm_nxt;
            rx_full_r <= rx_full_nxt;
            tx_buf_r <= tx_buf_nxt;
            tx_full_r <= tx_full_nxt;
            out_word_r <= out_word_nxt;
            out_busy_r <= out_busy_nxt;
            sda_drive_r <= sda_drive_nxt;
            req_low_r <= req_low_nxt;
            req_hold_r <= req_hold_nxt;
            stretch_r <= stretch_nxt;
            booted_r <= booted_nxt;
        end
    end

    // Open-drain pins: only ever pull low
    assign serial_ctrl_data_out = 1'b0;
    assign serial_ctrl_data_oe = sda_drive_r;
    assign serial_ctrl_clock_out = 1'b0;
    assign serial_ctrl_clock_oe = stretch_r;
    assign port_busy_n = ~(rx_full_r | stretch_r);
    assign port_busy_n_oe = rx_full_r | stretch_r;
    assign data_ready_req_n = ~req_low_r;
    assign data_ready_req_n_oe = req_low_r;
    assign rx_word.data = rx_buf_r;
    assign rx_word.valid = rx_full_r;
    assign tx_ready = ~tx_full_r;
endmodule // word_msg_port

/* File: tb/msg_port_props.sv */
// Checker for the word messaging port, watching only its top ports.
// Assumes a single clk domain; bound to every word_msg_port below.
`timescale 1ns/1ps
module msg_port_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic serial_ctrl_clock_in,
    input wire logic serial_ctrl_clock_oe,
    input wire logic serial_ctrl_data_oe,
    input wire logic port_busy_n,
    input wire logic port_busy_n_oe,
    input wire logic data_ready_req_n,
    input wire logic data_ready_req_n_oe,
    input wire logic boot_helper_loaded,
    input wire msg_port_pkg::msg_word_t rx_word,
    input wire logic rx_ready,
    input wire msg_port_pkg::msg_word_t tx_word,
    input wire logic tx_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic boot_r;
    logic boot_nxt;
    always_comb boot_nxt = boot_r | boot_helper_loaded;
    always_ff @(posedge clk) boot_r <= reset ? 1'b0 : boot_nxt;
    busy_pin_a: assert property (port_busy_n_oe == !port_busy_n)
        else $error("busy enable disagrees with level");
    req_pin_a: assert property (data_ready_req_n_oe == !data_ready_req_n)
        else $error("request enable disagrees with level");
    full_busy_a: assert property (rx_word.valid && !rx_ready |=> !port_busy_n)
        else $error("busy not low while a word is held");
    busy_rise_a: assert property ($rose(port_busy_n) |-> !rx_word.valid)
        else $error("busy released with buffer full");
    stretch_busy_a: assert property (serial_ctrl_clock_oe |-> !port_busy_n)
        else $error("clock stretched without busy");
    rx_hold_a: assert property (rx_word.valid && !rx_ready |=> rx_word.valid && $stable(rx_word.data))
        else $error("received word dropped before taken");
    boot_gate_a: assert property (!boot_r |-> data_ready_req_n)
        else $error("request active before boot");
    data_edge_a: assert property ($changed(serial_ctrl_data_oe) |-> !serial_ctrl_clock_in)
        else $error("data line moved while clock high");
    req_rise_a: assert property ($rose(data_ready_req_n) |-> serial_ctrl_clock_in)
        else $error("request rose outside a clock high phase");
    tx_take_a: assert property (tx_word.valid && tx_ready |=> !tx_ready)
        else $error("staging slot did not fill");
endmodule // msg_port_props

bind word_msg_port msg_port_props u_props (
    .clk, .reset, .serial_ctrl_clock_in, .serial_ctrl_clock_oe, .serial_ctrl_data_oe,
    .port_busy_n, .port_busy_n_oe, .data_ready_req_n, .data_ready_req_n_oe,
    .boot_helper_loaded, .rx_word, .rx_ready, .tx_word, .tx_ready
);

/* File: tb/host_model.sv */
// Bus master model driving the two open-drain lines low or releasing them.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/1ps
module host_model (
    input wire logic link_clk,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (8) @(posedge link_clk);
    endtask
    // Clock low on entry and exit; a stretched clock holds the bit
    task automatic bit_io(input logic b, output logic s);
        int n;
        sda_low <= !b;
        q();
        scl_low <= 1'b0;
        n = 0;
        while (scl_line !== 1'b1 && n < 20000) begin
            @(posedge link_clk);
            n++;
        end
        q();
        s = sda_line;
        scl_low <= 1'b1;
        q();
    endtask
    task automatic start();
        sda_low <= 1'b0;
        q();
        scl_low <= 1'b0;
        q();
        sda_low <= 1'b1;
        q();
        scl_low <= 1'b1;
        q();
    endtask
    task automatic stop();
        int n;
        sda_low <= 1'b1;
        q();
        scl_low <= 1'b0;
        // A stretched clock must end before the stop can be seen
        n = 0;
        while (scl_line !== 1'b1 && n < 20000) begin
            @(posedge link_clk);
            n++;
        end
        q();
        sda_low <= 1'b0;
        q();
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
endmodule // host_model

/* File: tb/word_msg_port_bench.sv */
// Bench for the word messaging port with the host model on the bus.
// System clock 10 MHz; the host steps on its own 80 ns clock.
`timescale 1ns/1ps
module word_msg_port_bench;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic boot_helper_loaded = 1'b0;
    logic rx_ready = 1'b0;
    msg_port_pkg::msg_word_t tx_word = '0;
    msg_port_pkg::msg_word_t rx_word;
    logic scl_low, sda_low, clk_oe, dat_oe, busy_n, req_n, tx_ready;
    wire scl = !(scl_low | clk_oe);
    wire sda = !(sda_low | dat_oe);
    int n_tests = 0;
    int n_mismatch = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h96f1_5ee9;
    logic [31:0] exp_q[$];
    logic [31:0] rd [2];
    logic stretched = 1'b0;
    initial forever #50 clk = !clk;
    initial begin
        #23;
        forever #40 link_clk = !link_clk;
    end
    word_msg_port dut (.clk, .reset, .serial_ctrl_clock_in(scl), .serial_ctrl_clock_out(),
        .serial_ctrl_clock_oe(clk_oe), .serial_ctrl_data_in(sda), .serial_ctrl_data_out(),
        .serial_ctrl_data_oe(dat_oe), .port_busy_n(busy_n), .port_busy_n_oe(),
        .data_ready_req_n(req_n), .data_ready_req_n_oe(), .boot_helper_loaded,
        .rx_word, .rx_ready, .tx_word, .tx_ready);
    host_model host (.link_clk, .scl_line(scl), .sda_line(sda), .scl_low, .sda_low);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic offer(input logic [31:0] w);
        tx_word <= '{data: w, valid: 1'b1};
        @(negedge clk);
        while (tx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (clk_oe === 1'b1) stretched <= 1'b1;
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // Slow consumer, so later bytes meet a full buffer
    initial forever begin
        @(posedge clk);
        rx_ready <= 1'b0;
        if (rx_word.valid === 1'b1 && rx_ready === 1'b0) begin
            repeat (1000 + rnd() % 500) @(posedge clk);
            check("busy_n", busy_n, 0);
            check("rx_word", rx_word.data, exp_q.pop_front());
            rx_ready <= 1'b1;
        end
    end
    initial begin : main
        logic [31:0] w;
        logic [7:0] b;
        logic a;
        logic s;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        check("busy_n", busy_n, 1);
        check("req_n", req_n, 1);
        check("tx_ready", tx_ready, 1);
        host.start();
        host.wr_byte(8'h82, a);
        check("ack_other", a, 0);
        host.stop();
        host.start();
        host.wr_byte(msg_port_pkg::ADDR_WRITE, a);
        check("ack_addr", a, 1);
        repeat (3) begin
            w = rnd();
            exp_q.push_back(w);
            for (int i = 3; i >= 0; i--) begin
                host.wr_byte(w[8*i +: 8], a);
                check("ack_data", a, 1);
            end
        end
        host.stop();
        while (exp_q.size() > 0) @(posedge clk);
        check("stretch", stretched, 1);
        rd[0] = rnd();
        rd[1] = rnd();
        fork
            begin
                offer(rd[0]);
                offer(rd[1]);
                tx_word <= '0;
            end
        join_none
        repeat (100) @(posedge clk);
        check("req_n", req_n, 1);
        boot_helper_loaded <= 1'b1;
        repeat (20) @(posedge clk);
        check("req_n", req_n, 0);
        host.start();
        host.wr_byte(msg_port_pkg::ADDR_READ, a);
        check("ack_rd", a, 1);
        for (int j = 0; j < 8; j++) begin
            for (int i = 7; i >= 0; i--) host.bit_io(1'b1, b[i]);
            check("rd_byte", b, rd[j/4][8*(3-j%4) +: 8]);
            check("req_n", req_n, j == 7);
            host.bit_io(!((j % 4 != 3) || req_n === 1'b0), s);
        end
        host.stop();
        repeat (100) @(posedge clk);
        check("req_n", req_n, 1);
        print_verdict();
    end
endmodule // word_msg_port_bench
